/* shared/branch_bit_flag_pkg.sv */
// constants, types and register map of the branch, bit and flag execution unit
package branch_bit_flag_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_INSTR = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_PC = 12'h008;
  localparam logic [11:0] ADDR_STATUS_REGISTER = 12'h00C;
  localparam logic [11:0] ADDR_GPR_BASE = 12'h100;
  localparam logic [11:0] ADDR_IO_BASE = 12'h200;
  localparam logic [11:0] ADDR_WIN_MASK = 12'hF80;
  localparam int NUM_GPR = 32;
  localparam int NUM_IO = 32;

  // ****************************************
  // status register bit positions
  // ****************************************
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_N = 2;
  localparam int SR_V = 3;
  localparam int SR_S = 4;
  localparam int SR_H = 5;
  localparam int SR_T = 6;
  localparam int SR_I = 7;

  // ****************************************
  // reset values and bus answers
  // ****************************************
  localparam logic [7:0] STATUS_REGISTER_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  // ****************************************
  // operation codes of the instruction word
  // ****************************************
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_BRANCH_SIGNED_GE = 5'h01,
    OP_BRANCH_SIGNED_LT = 5'h02,
    OP_BRANCH_HALF_CARRY_SET = 5'h03,
    OP_BRANCH_HALF_CARRY_CLEAR = 5'h04,
    OP_BRANCH_TRANSFER_FLAG_SET = 5'h05,
    OP_BRANCH_TRANSFER_FLAG_CLEAR = 5'h06,
    OP_BRANCH_OVERFLOW_SET = 5'h07,
    OP_BRANCH_OVERFLOW_CLEAR = 5'h08,
    OP_BRANCH_IRQ_ENABLED = 5'h09,
    OP_BRANCH_IRQ_DISABLED = 5'h0A,
    OP_IO_BIT_SET = 5'h0B,
    OP_IO_BIT_CLEAR = 5'h0C,
    OP_ROTATE_LEFT_CARRY = 5'h0D,
    OP_ROTATE_RIGHT_CARRY = 5'h0E,
    OP_ARITH_SHIFT_RIGHT = 5'h0F,
    OP_BIT_TO_TRANSFER_FLAG = 5'h10,
    OP_TRANSFER_FLAG_TO_BIT = 5'h11,
    OP_OVERFLOW_FLAG_SET = 5'h12,
    OP_OVERFLOW_FLAG_CLEAR = 5'h13,
    OP_HALF_CARRY_SET = 5'h14,
    OP_HALF_CARRY_CLEAR = 5'h15,
    OP_SIGN_FLAG_SET = 5'h16,
    OP_SIGN_FLAG_CLEAR = 5'h17,
    OP_IRQ_ENABLE_INSTR = 5'h18,
    OP_IRQ_DISABLE_INSTR = 5'h19
  } op_t;

  localparam logic [4:0] OP_LAST = 5'h19;

  // instruction word: op [4:0], bit [7:5], reg/port index [12:8], offset k [19:13]
  typedef struct packed {
    logic [11:0] unused;
    logic [6:0] k;
    logic [4:0] idx;
    logic [2:0] bit_sel;
    logic [4:0] op;
  } instr_t;

  // status word read at ADDR_STATUS
  typedef struct packed {
    logic [26:0] unused;
    logic illegal;
    logic [1:0] cycles;
    logic taken;
    logic busy;
  } status_t;

endpackage : branch_bit_flag_pkg

/* core/branch_bit_flag_ops.sv */
// execution unit for flag branches, i/o bit ops, carry rotates, transfer bit and flag ops
//
// The AXI4-Lite slave port and the register offsets were decided locally.
module branch_bit_flag_ops (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_busy
);

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SECOND} state_t;

  // ****************************************
  // functions
  // ****************************************
  function automatic logic in_window(input logic [11:0] a, input logic [11:0] base);
    in_window = ((a & branch_bit_flag_pkg::ADDR_WIN_MASK) == base) && (a[1:0] == 2'h0);
  endfunction : in_window

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == branch_bit_flag_pkg::ADDR_INSTR) || (a == branch_bit_flag_pkg::ADDR_STATUS)
      || (a == branch_bit_flag_pkg::ADDR_PC) || (a == branch_bit_flag_pkg::ADDR_STATUS_REGISTER)
      || in_window(a, branch_bit_flag_pkg::ADDR_GPR_BASE)
      || in_window(a, branch_bit_flag_pkg::ADDR_IO_BASE);
  endfunction : is_mapped

  function automatic logic [7:0] low_byte(input logic [7:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    low_byte = strb[0] ? d[7:0] : old;
  endfunction : low_byte

  // z, c, n and v for a shift result; v is n xor c
  function automatic logic [7:0] shift_flags(input logic [7:0] sr, input logic [7:0] res,
                                             input logic c);
    logic [7:0] f;
    f = sr;
    f[branch_bit_flag_pkg::SR_Z] = (res == 8'h00);
    f[branch_bit_flag_pkg::SR_C] = c;
    f[branch_bit_flag_pkg::SR_N] = res[7];
    f[branch_bit_flag_pkg::SR_V] = res[7] ^ c;
    shift_flags = f;
  endfunction : shift_flags

  // ****************************************
  // state
  // ****************************************
  state_t state;
  branch_bit_flag_pkg::instr_t instr;
  logic [15:0] pc;
  logic [7:0] status_register;
  logic [7:0] gpr [branch_bit_flag_pkg::NUM_GPR];
  logic [7:0] io_reg [branch_bit_flag_pkg::NUM_IO];
  logic last_taken;
  logic [1:0] last_cycles;
  logic last_illegal;

  logic aw_hold;
  logic [11:0] aw_addr;
  logic w_hold;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // ****************************************
  // write decode
  // ****************************************
  logic do_write;
  logic wr_ok;
  logic wr_instr;
  logic wr_pc;
  logic wr_status_register;
  logic wr_gpr;
  logic wr_io;
  logic [4:0] wr_idx;

  assign do_write = aw_hold && w_hold && !o_bvalid;
  // state is only writable while idle, so bus and execution never collide
  assign wr_ok = do_write && is_mapped(aw_addr) && (state == ST_IDLE);
  assign wr_instr = wr_ok && (aw_addr == branch_bit_flag_pkg::ADDR_INSTR) && w_strb[0];
  assign wr_pc = wr_ok && (aw_addr == branch_bit_flag_pkg::ADDR_PC);
  assign wr_status_register = wr_ok && (aw_addr == branch_bit_flag_pkg::ADDR_STATUS_REGISTER) && w_strb[0];
  assign wr_gpr = wr_ok && in_window(aw_addr, branch_bit_flag_pkg::ADDR_GPR_BASE) && w_strb[0];
  assign wr_io = wr_ok && in_window(aw_addr, branch_bit_flag_pkg::ADDR_IO_BASE) && w_strb[0];
  assign wr_idx = aw_addr[6:2];

  // ****************************************
  // execution decode
  // ****************************************
  logic exec;
  logic cond;
  logic is_branch;
  logic illegal;
  logic [7:0] rd;
  logic [7:0] next_rd;
  logic [7:0] next_status_register;
  logic rd_write;
  logic [15:0] pc_plus1;
  logic [15:0] pc_target;

  assign exec = (state == ST_EXEC);
  assign rd = gpr[instr.idx];
  assign pc_plus1 = pc + 16'h0001;
  assign pc_target = pc_plus1 + {{9{instr.k[6]}}, instr.k};
  assign illegal = (instr.op > branch_bit_flag_pkg::OP_LAST);

  always_comb
  begin
    cond = 1'b0;
    is_branch = 1'b1;
    unique case (instr.op)
      branch_bit_flag_pkg::OP_BRANCH_SIGNED_GE:
        cond = !(status_register[branch_bit_flag_pkg::SR_N] ^ status_register[branch_bit_flag_pkg::SR_V]);
      branch_bit_flag_pkg::OP_BRANCH_SIGNED_LT:
        cond = status_register[branch_bit_flag_pkg::SR_N] ^ status_register[branch_bit_flag_pkg::SR_V];
      branch_bit_flag_pkg::OP_BRANCH_HALF_CARRY_SET:
        cond = status_register[branch_bit_flag_pkg::SR_H];
      branch_bit_flag_pkg::OP_BRANCH_HALF_CARRY_CLEAR:
        cond = !status_register[branch_bit_flag_pkg::SR_H];
      branch_bit_flag_pkg::OP_BRANCH_TRANSFER_FLAG_SET:
        cond = status_register[branch_bit_flag_pkg::SR_T];
      branch_bit_flag_pkg::OP_BRANCH_TRANSFER_FLAG_CLEAR:
        cond = !status_register[branch_bit_flag_pkg::SR_T];
      branch_bit_flag_pkg::OP_BRANCH_OVERFLOW_SET:
        cond = status_register[branch_bit_flag_pkg::SR_V];
      branch_bit_flag_pkg::OP_BRANCH_OVERFLOW_CLEAR:
        cond = !status_register[branch_bit_flag_pkg::SR_V];
      branch_bit_flag_pkg::OP_BRANCH_IRQ_ENABLED:
        cond = status_register[branch_bit_flag_pkg::SR_I];
      branch_bit_flag_pkg::OP_BRANCH_IRQ_DISABLED:
        cond = !status_register[branch_bit_flag_pkg::SR_I];
      default:
        is_branch = 1'b0;
    endcase
  end

  // register and flag results; branches and i/o bit ops leave status_register alone
  always_comb
  begin
    next_rd = rd;
    next_status_register = status_register;
    rd_write = 1'b0;
    unique case (instr.op)
      branch_bit_flag_pkg::OP_ROTATE_LEFT_CARRY:
      begin
        next_rd = {rd[6:0], status_register[branch_bit_flag_pkg::SR_C]};
        next_status_register = shift_flags(status_register, next_rd, rd[7]);
        rd_write = 1'b1;
      end
      branch_bit_flag_pkg::OP_ROTATE_RIGHT_CARRY:
      begin
        next_rd = {status_register[branch_bit_flag_pkg::SR_C], rd[7:1]};
        next_status_register = shift_flags(status_register, next_rd, rd[0]);
        rd_write = 1'b1;
      end
      branch_bit_flag_pkg::OP_ARITH_SHIFT_RIGHT:
      begin
        next_rd = {rd[7], rd[7:1]};
        next_status_register = shift_flags(status_register, next_rd, rd[0]);
        rd_write = 1'b1;
      end
      branch_bit_flag_pkg::OP_BIT_TO_TRANSFER_FLAG:
        next_status_register[branch_bit_flag_pkg::SR_T] = rd[instr.bit_sel];
      branch_bit_flag_pkg::OP_TRANSFER_FLAG_TO_BIT:
      begin
        next_rd[instr.bit_sel] = status_register[branch_bit_flag_pkg::SR_T];
        rd_write = 1'b1;
      end
      branch_bit_flag_pkg::OP_OVERFLOW_FLAG_SET:
        next_status_register[branch_bit_flag_pkg::SR_V] = 1'b1;
      branch_bit_flag_pkg::OP_OVERFLOW_FLAG_CLEAR:
        next_status_register[branch_bit_flag_pkg::SR_V] = 1'b0;
      branch_bit_flag_pkg::OP_HALF_CARRY_SET:
        next_status_register[branch_bit_flag_pkg::SR_H] = 1'b1;
      branch_bit_flag_pkg::OP_HALF_CARRY_CLEAR:
        next_status_register[branch_bit_flag_pkg::SR_H] = 1'b0;
      branch_bit_flag_pkg::OP_SIGN_FLAG_SET:
        next_status_register[branch_bit_flag_pkg::SR_S] = 1'b1;
      branch_bit_flag_pkg::OP_SIGN_FLAG_CLEAR:
        next_status_register[branch_bit_flag_pkg::SR_S] = 1'b0;
      branch_bit_flag_pkg::OP_IRQ_ENABLE_INSTR:
        next_status_register[branch_bit_flag_pkg::SR_I] = 1'b1;
      branch_bit_flag_pkg::OP_IRQ_DISABLE_INSTR:
        next_status_register[branch_bit_flag_pkg::SR_I] = 1'b0;
      default:
      begin
        next_rd = rd;
        next_status_register = status_register;
      end
    endcase
  end

  // ****************************************
  // sequencer
  // ****************************************
  logic two_cycle;

  assign two_cycle = (is_branch && cond)
    || (instr.op == branch_bit_flag_pkg::OP_IO_BIT_SET)
    || (instr.op == branch_bit_flag_pkg::OP_IO_BIT_CLEAR);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      state <= ST_IDLE;
      instr <= '0;
      o_busy <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
          if (wr_instr)
          begin
            instr <= branch_bit_flag_pkg::instr_t'(w_data);
            state <= ST_EXEC;
            o_busy <= 1'b1;
          end
        ST_EXEC:
          if (two_cycle && !illegal)
          begin
            state <= ST_SECOND;
          end
          else
          begin
            state <= ST_IDLE;
            o_busy <= 1'b0;
          end
        ST_SECOND:
        begin
          state <= ST_IDLE;
          o_busy <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      last_taken <= 1'b0;
      last_cycles <= 2'h0;
      last_illegal <= 1'b0;
    end
    else if (exec)
    begin
      last_taken <= is_branch && cond && !illegal;
      last_cycles <= (two_cycle && !illegal) ? branch_bit_flag_pkg::CYC_TWO
        : branch_bit_flag_pkg::CYC_ONE;
      last_illegal <= illegal;
    end
  end

  // ****************************************
  // program counter and status register
  // ****************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      pc <= branch_bit_flag_pkg::PC_RST;
    end
    else if (wr_pc)
    begin
      pc <= {(w_strb[1] ? w_data[15:8] : pc[15:8]), low_byte(pc[7:0], w_data, w_strb)};
    end
    else if (exec && !illegal)
    begin
      pc <= (is_branch && cond) ? pc_target : pc_plus1;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      status_register <= branch_bit_flag_pkg::STATUS_REGISTER_RST;
    end
    else if (wr_status_register)
    begin
      status_register <= w_data[7:0];
    end
    else if (exec && !illegal)
    begin
      status_register <= next_status_register;
    end
  end

  // ****************************************
  // working registers and i/o space
  // ****************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      for (int i = 0; i < branch_bit_flag_pkg::NUM_GPR; i++)
      begin
        gpr[i] <= branch_bit_flag_pkg::DATA_RST;
      end
    end
    else if (wr_gpr)
    begin
      gpr[wr_idx] <= w_data[7:0];
    end
    else if (exec && !illegal && rd_write)
    begin
      gpr[instr.idx] <= next_rd;
    end
  end

  // the port bit is written in the first cycle; the second only holds the unit busy
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      for (int i = 0; i < branch_bit_flag_pkg::NUM_IO; i++)
      begin
        io_reg[i] <= branch_bit_flag_pkg::DATA_RST;
      end
    end
    else if (wr_io)
    begin
      io_reg[wr_idx] <= w_data[7:0];
    end
    else if (exec && (instr.op == branch_bit_flag_pkg::OP_IO_BIT_SET))
    begin
      io_reg[instr.idx][instr.bit_sel] <= 1'b1;
    end
    else if (exec && (instr.op == branch_bit_flag_pkg::OP_IO_BIT_CLEAR))
    begin
      io_reg[instr.idx][instr.bit_sel] <= 1'b0;
    end
  end

  // ****************************************
  // bus write channels
  // ****************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      aw_hold <= 1'b0;
      aw_addr <= 12'h000;
      o_awready <= 1'b1;
    end
    else if (o_awready && i_awvalid)
    begin
      aw_hold <= 1'b1;
      aw_addr <= i_awaddr;
      o_awready <= 1'b0;
    end
    else if (do_write)
    begin
      aw_hold <= 1'b0;
    end
    else if (o_bvalid && i_bready)
    begin
      o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      w_hold <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_wready <= 1'b1;
    end
    else if (o_wready && i_wvalid)
    begin
      w_hold <= 1'b1;
      w_data <= i_wdata;
      w_strb <= i_wstrb;
      o_wready <= 1'b0;
    end
    else if (do_write)
    begin
      w_hold <= 1'b0;
    end
    else if (o_bvalid && i_bready)
    begin
      o_wready <= 1'b1;
    end
  end

  // unmapped addresses and writes while busy are refused with slverr
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_bvalid <= 1'b0;
      o_bresp <= branch_bit_flag_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      o_bvalid <= 1'b1;
      o_bresp <= wr_ok ? branch_bit_flag_pkg::RESP_OKAY : branch_bit_flag_pkg::RESP_SLVERR;
    end
    else if (o_bvalid && i_bready)
    begin
      o_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // bus read channel
  // ****************************************
  branch_bit_flag_pkg::status_t stat;
  logic [31:0] rd_mux;

  always_comb
  begin
    stat = '0;
    stat.busy = o_busy;
    stat.taken = last_taken;
    stat.cycles = last_cycles;
    stat.illegal = last_illegal;
    rd_mux = 32'h0000_0000;
    if (i_araddr == branch_bit_flag_pkg::ADDR_INSTR)
      rd_mux = 32'(instr);
    else if (i_araddr == branch_bit_flag_pkg::ADDR_STATUS)
      rd_mux = 32'(stat);
    else if (i_araddr == branch_bit_flag_pkg::ADDR_PC)
      rd_mux = {16'h0000, pc};
    else if (i_araddr == branch_bit_flag_pkg::ADDR_STATUS_REGISTER)
      rd_mux = {24'h00_0000, status_register};
    else if (in_window(i_araddr, branch_bit_flag_pkg::ADDR_GPR_BASE))
      rd_mux = {24'h00_0000, gpr[i_araddr[6:2]]};
    else if (in_window(i_araddr, branch_bit_flag_pkg::ADDR_IO_BASE))
      rd_mux = {24'h00_0000, io_reg[i_araddr[6:2]]};
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= branch_bit_flag_pkg::RESP_OKAY;
    end
    else if (o_arready && i_arvalid)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_mux;
      o_rresp <= is_mapped(i_araddr) ? branch_bit_flag_pkg::RESP_OKAY
        : branch_bit_flag_pkg::RESP_SLVERR;
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

endmodule : branch_bit_flag_ops

/* sim/branch_bit_flag_ops_chk.sv */
// assertions on the bus and execution ports of the branch, bit and flag unit
module branch_bit_flag_ops_chk (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic o_busy
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  // ****************************************
  // bus handshakes
  // ****************************************
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
    else $error("read answer not one cycle after address");
  a_read_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)
    && $stable(o_rresp)) else $error("read answer dropped or changed");
  a_read_release: assert property (o_rvalid && i_rready |=> !o_rvalid && o_arready)
    else $error("read channel not released");
  a_unmapped_read: assert property (i_arvalid && o_arready && i_araddr >= 12'h280 |=>
    o_rresp == branch_bit_flag_pkg::RESP_SLVERR && o_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=>
    !o_bvalid ##1 o_bvalid) else $error("write answer timing wrong");
  a_write_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write answer dropped or changed");
  a_write_release: assert property (o_bvalid && i_bready |=> !o_bvalid && o_awready
    && o_wready) else $error("write channel not released");

  // ****************************************
  // execution timing
  // ****************************************
  a_busy_short: assert property ($rose(o_busy) |=> ##[0:1] !o_busy)
    else $error("instruction longer than two cycles");
  a_busy_start: assert property ($rose(o_busy) |-> o_bvalid)
    else $error("execution started without instruction write");

  cover property ($rose(o_busy) ##1 o_busy);
  cover property ($rose(o_busy) ##1 !o_busy);
  cover property (o_rvalid && o_rresp == branch_bit_flag_pkg::RESP_SLVERR);
endmodule : branch_bit_flag_ops_chk

bind branch_bit_flag_ops branch_bit_flag_ops_chk i_branch_bit_flag_ops_chk (.*);

/* sim/branch_bit_flag_ops_tb.sv */
// self-checking bench for the branch, bit and flag unit over its register bus
module branch_bit_flag_ops_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] ad_instr = branch_bit_flag_pkg::ADDR_INSTR;
  localparam logic [11:0] ad_stat = branch_bit_flag_pkg::ADDR_STATUS;
  localparam logic [11:0] ad_pc = branch_bit_flag_pkg::ADDR_PC;
  localparam logic [11:0] ad_status_register = branch_bit_flag_pkg::ADDR_STATUS_REGISTER;
  localparam logic [11:0] ad_gpr = branch_bit_flag_pkg::ADDR_GPR_BASE;
  localparam logic [11:0] ad_io = branch_bit_flag_pkg::ADDR_IO_BASE;
  localparam logic [7:0] sr_tab [4] = '{8'h00, 8'hFF, 8'h0C, 8'h64};
  // flag positions: h, t, v, i for branches; v, h, s, i for flag ops
  localparam int br_tab [4] = '{5, 6, 3, 7};
  localparam int fl_tab [4] = '{3, 5, 4, 7};
  localparam logic [7:0] sh_tab [4] = '{8'h80, 8'h01, 8'h00, 8'hC3};
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_awvalid = 1'b0;
  logic i_wvalid = 1'b0;
  logic i_bready = 1'b0;
  logic i_arvalid = 1'b0;
  logic i_rready = 1'b0;
  logic [11:0] i_awaddr = 12'h000;
  logic [11:0] i_araddr = 12'h000;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [3:0] i_wstrb = 4'hF;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_busy;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata, st, d, x32;
  logic [1:0] r;
  int fails = 0;
  int samples_checked = 0;
  // slow makes the master raise ready only once the answer is seen, so the slave must hold it
  bit slow = 1'b0;

  branch_bit_flag_ops i_branch_bit_flag_ops (.*);

  always #2.5 i_ref_clk = ~i_ref_clk;

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] dv, output logic [1:0] rs);
    logic got;
    got = 1'b0;
    @(posedge i_ref_clk);
    i_awaddr <= a;
    i_wdata <= dv;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= !slow;
    while (!got)
    begin
      @(posedge i_ref_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      got = (o_bvalid === 1'b1) && i_bready;
      rs = o_bresp;
      if ((o_bvalid === 1'b1) && !i_bready) i_bready <= 1'b1;
    end
    i_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] dv, output logic [1:0] rs);
    logic got;
    got = 1'b0;
    @(posedge i_ref_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= !slow;
    while (!got)
    begin
      @(posedge i_ref_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      got = (o_rvalid === 1'b1) && i_rready;
      dv = o_rdata;
      rs = o_rresp;
      if ((o_rvalid === 1'b1) && !i_rready) i_rready <= 1'b1;
    end
    i_rready <= 1'b0;
  endtask : rd

  task automatic w(input logic [11:0] a, input logic [31:0] dv);
    logic [1:0] rs;
    wr(a, dv, rs);
    chk("write resp", {30'h0, rs}, {30'h0, branch_bit_flag_pkg::RESP_OKAY});
  endtask : w

  // snapshot is {pc, status_register, status low byte} after the instruction retires
  task automatic run(input logic [4:0] op, input logic [2:0] b, input logic [4:0] ix,
    input logic [6:0] k, input logic [7:0] sr, output logic [31:0] v);
    logic [31:0] p;
    w(ad_status_register, {24'h0, sr});
    w(ad_pc, 32'h0000_1234);
    w(ad_instr, {12'h000, k, ix, b, op});
    st = 32'h0000_0001;
    while (st[0] !== 1'b0) rd(ad_stat, st, r);
    rd(ad_pc, p, r);
    rd(ad_status_register, v, r);
    chk("read resp", {30'h0, r}, {30'h0, branch_bit_flag_pkg::RESP_OKAY});
    v = {p[15:0], v[7:0], st[7:0]};
  endtask : run

  function automatic logic cond(input int op, input logic [7:0] s);
    logic v;
    v = (op < 3) ? s[2] ^ s[3] : s[br_tab[(op - 3) / 2]];
    return (op inside {1, 4, 6, 8, 10}) ? ~v : v;
  endfunction : cond

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    logic [31:0] v;
    logic [7:0] x;
    logic [7:0] e;
    logic c;
    logic tk;
    repeat (4) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    rd(ad_pc, d, r);
    chk("reset pc", d, 32'h0000_0000);
    for (int op = 1; op <= 10; op++)
      for (int i = 0; i < 4; i++)
      begin
        run(5'(op), 3'h0, 5'h00, i[0] ? 7'h3F : 7'h40, sr_tab[i], v);
        tk = cond(op, sr_tab[i]);
        x32 = {tk ? (i[0] ? 16'h1274 : 16'h11F5) : 16'h1235, sr_tab[i], tk ? 8'h0A : 8'h04};
        if (op < 6) chk("branch", v, x32);
        else chk("branch", v, x32);
      end
    for (int op = 18; op <= 25; op++)
      for (int i = 0; i < 2; i++)
      begin
        e = i[0] ? 8'hFF : 8'h00;
        run(5'(op), 3'h0, 5'h00, 7'h00, e, v);
        e[fl_tab[(op - 18) / 2]] = ~op[0];
        chk("flag op", v, {16'h1235, e, 8'h04});
      end
    for (int op = 13; op <= 15; op++)
      for (int i = 0; i < 4; i++)
      begin
        x = sh_tab[i];
        c = i[1];
        w(ad_gpr + 12'h01C, {24'h0, x});
        run(5'(op), 3'h0, 5'h07, 7'h00, {7'h78, c}, v);
        e = (op == 13) ? {x[6:0], c} : {(op == 14) ? c : x[7], x[7:1]};
        c = (op == 13) ? x[7] : x[0];
        x32 = {16'h1235, 4'hF, e[7] ^ c, e[7], e == 8'h00, c, 8'h04};
        chk("shift flags", v, x32);
        rd(ad_gpr + 12'h01C, d, r);
        chk("shift data", d, {24'h0, e});
      end
    w(ad_io + 12'h014, 32'h0000_00A5);
    run(5'h0B, 3'h1, 5'h05, 7'h00, 8'h5A, v);
    chk("io set", v, {16'h1235, 8'h5A, 8'h08});
    rd(ad_io + 12'h014, d, r);
    chk("io set data", d, 32'h0000_00A7);
    run(5'h0C, 3'h7, 5'h05, 7'h00, 8'hA5, v);
    chk("io clear", v, {16'h1235, 8'hA5, 8'h08});
    rd(ad_io + 12'h014, d, r);
    chk("io clear data", d, 32'h0000_0027);
    w(ad_gpr + 12'h00C, 32'h0000_0040);
    w(ad_gpr + 12'h010, 32'h0000_00F0);
    for (int i = 0; i < 2; i++)
    begin
      e = i ? 8'hBF : 8'hFF;
      run(5'h10, i ? 3'h0 : 3'h6, 5'h03, 7'h00, e ^ 8'h40, v);
      chk("bit store", v, {16'h1235, e, 8'h04});
      run(5'h11, i ? 3'h7 : 3'h0, 5'h04, 7'h00, e, v);
      chk("bit load", v, {16'h1235, e, 8'h04});
      rd(ad_gpr + 12'h010, d, r);
      chk("bit load data", d, i ? 32'h0000_0071 : 32'h0000_00F1);
    end
    run(5'h00, 3'h0, 5'h00, 7'h00, 8'h3C, v);
    chk("no operation", v, {16'h1235, 8'h3C, 8'h04});
    // unknown code must leave pc alone and only flag itself
    run(5'h1A, 3'h0, 5'h00, 7'h00, 8'h3C, v);
    chk("illegal op", v, {16'h1234, 8'h3C, 8'h14});
    slow = 1'b1;
    rd(12'hFFC, d, r);
    chk("unmapped read", {d[29:0], r}, {30'h0, branch_bit_flag_pkg::RESP_SLVERR});
    wr(12'hFFC, 32'h0000_0001, r);
    chk("unmapped write", {30'h0, r}, {30'h0, branch_bit_flag_pkg::RESP_SLVERR});
    end_sim();
  end

  // whole run is near 2k cycles; the limit leaves ample margin
  initial
  begin
    #40us;
    fails++;
    end_sim();
  end
endmodule : branch_bit_flag_ops_tb
